// ### src/odsw_defs.svh
// Constants for the opcode decoder and power-down / wake-up controller
// Function
// - Power-down clears watchdog and power-down flag, sets timeout flag, stops oscillator
// - Pins hold their pre-power-down drive state
// - Wake on reset pin, watchdog, enabled interrupt
// - Watchdog wake clears the timeout flag
// - Power-down flag set at power-up, cleared by power-down
// - Listed peripheral interrupts are valid wake sources
// - Clock-dependent peripherals cannot wake the core
// - Power-down prefetches the next program address
// - Wake needs source enable, ignores global enable
// - Run prefetched word, then vector if globally enabled
// - Pending enabled interrupt makes power-down a no-op
// - Late interrupt: power-down completes, then wakes at once
// - Byte ops: add, and, subtract, or, xor codes
// - Byte ops: move, complement, dec, inc, rotates, swap
// - Skip-if-zero ops take two cycles when skipping
// - Bit ops: clear, set, two test-and-skip forms
// - Call and jump carry 11-bit target, two cycles
// - Literal ops under prefix 11 with 8-bit literal
// - Fixed codes: power-down, watchdog clear, two returns
// - Each op updates its documented status flags
`ifndef ODSW_DEFS_SVH
`define ODSW_DEFS_SVH

`define ODSW_IW             14
`define ODSW_PCW            13
`define ODSW_TGTW           11
`define ODSW_IO_W           8
`define ODSW_IRQ_N          16
`define ODSW_WDT_W          24

`define ODSW_PC_RESET       13'h0000
`define ODSW_PC_VECTOR      13'h0004
`define ODSW_WDT_CYCLES_DEF 24'h040000

// Bits 0..10: ext pin, port change, slave port, async timer one,
// capture, special event, start/stop, serial slave, sync usart,
// rc-clocked converter, low voltage. Bits 11..15 need core clocks.
`define ODSW_WAKE_MASK      16'h07FF

`define ODSW_PFX_BYTE       2'h0
`define ODSW_PFX_BIT        2'h1
`define ODSW_PFX_CTRL       2'h2
`define ODSW_PFX_LIT        2'h3

`define ODSW_B_MISC         4'h0
`define ODSW_B_CLR          4'h1
`define ODSW_B_SUB          4'h2
`define ODSW_B_DEC          4'h3
`define ODSW_B_OR           4'h4
`define ODSW_B_AND          4'h5
`define ODSW_B_XOR          4'h6
`define ODSW_B_ADD          4'h7
`define ODSW_B_MOVE         4'h8
`define ODSW_B_COMP         4'h9
`define ODSW_B_INC          4'hA
`define ODSW_B_DECSKZ       4'hB
`define ODSW_B_RR           4'hC
`define ODSW_B_RL           4'hD
`define ODSW_B_SWAP         4'hE
`define ODSW_B_INCSKZ       4'hF

`define ODSW_BIT_CLR        2'h0
`define ODSW_BIT_SET        2'h1
`define ODSW_BIT_TSTC       2'h2
`define ODSW_BIT_TSTS       2'h3

`define ODSW_L_LOAD         2'h0
`define ODSW_L_RET          2'h1
`define ODSW_L_OR           4'h8
`define ODSW_L_AND          4'h9
`define ODSW_L_XOR          4'hA
`define ODSW_L_SUB          3'h6
`define ODSW_L_ADD          3'h7

`define ODSW_CODE_SLEEP     14'h0063
`define ODSW_CODE_WDTCLR    14'h0064
`define ODSW_CODE_IRQRET    14'h0009
`define ODSW_CODE_RET       14'h0008
`define ODSW_NOP_LOW        5'h00

`endif

// ### src/odsw_pkg.sv
// Types shared by the decoder and the sequencer
`include "odsw_defs.svh"
package odsw_pkg;

    typedef enum logic [5:0] {
        OP_NOP, OP_STORE_ACC, OP_CLR_ACC, OP_CLR_FILE,
        OP_SUB, OP_DEC, OP_OR, OP_AND, OP_XOR, OP_ADD,
        OP_MOVE, OP_COMP, OP_INC, OP_DEC_SKZ, OP_RR, OP_RL,
        OP_SWAP, OP_INC_SKZ,
        OP_BIT_CLR, OP_BIT_SET, OP_TEST_CLR, OP_TEST_SET,
        OP_CALL, OP_JUMP,
        OP_LIT_LOAD, OP_LIT_RET, OP_LIT_OR, OP_LIT_AND,
        OP_LIT_XOR, OP_LIT_SUB, OP_LIT_ADD,
        OP_POWERDOWN, OP_WDT_CLEAR, OP_IRQ_RET, OP_RET,
        OP_ILLEGAL
    } odsw_op_t;

    typedef enum {ST_RUN, ST_SLEEP} odsw_state_t;

    typedef struct packed {
        odsw_op_t               op;
        logic                   dest;
        logic [6:0]             faddr;
        logic [2:0]             bitn;
        logic [7:0]             lit;
        logic [`ODSW_TGTW-1:0]  target;
        logic                   two_cycle;
        logic                   may_skip;
        logic                   upd_c;
        logic                   upd_hc;
        logic                   upd_z;
        logic                   upd_tp;
    } odsw_dec_t;

    typedef struct packed {
        logic                   valid;
        logic                   nop_slot;
    } odsw_exec_t;

    typedef struct packed {
        logic [`ODSW_IO_W-1:0]  out;
        logic [`ODSW_IO_W-1:0]  oe;
    } odsw_io_t;

endpackage : odsw_pkg

// ### src/odsw_decoder.sv
// Combinational decode of one 14-bit instruction word
`timescale 1ns/1ps
`include "odsw_defs.svh"
module odsw_decoder
    import odsw_pkg::*;
(
    input  wire logic [`ODSW_IW-1:0] instr_i,
    output odsw_dec_t                dec_o
);
    // Field split shared by all instruction groups
    wire logic [1:0] pfx = instr_i[13:12];
    wire logic [3:0] op4 = instr_i[11:8];
    wire logic       d   = instr_i[7];
    odsw_op_t        op;

    // Operation select; undefined words fall to the illegal code
    always_comb begin
        op = OP_ILLEGAL;
        unique case (pfx)
            `ODSW_PFX_BYTE: begin
                unique case (op4)
                    `ODSW_B_MISC: begin
                        if (instr_i == `ODSW_CODE_SLEEP)
                            op = OP_POWERDOWN;
                        else if (instr_i == `ODSW_CODE_WDTCLR)
                            op = OP_WDT_CLEAR;
                        else if (instr_i == `ODSW_CODE_IRQRET)
                            op = OP_IRQ_RET;
                        else if (instr_i == `ODSW_CODE_RET)
                            op = OP_RET;
                        else if (d)
                            op = OP_STORE_ACC;
                        else if (instr_i[4:0] == `ODSW_NOP_LOW)
                            op = OP_NOP;
                    end
                    `ODSW_B_CLR:    op = d ? OP_CLR_FILE : OP_CLR_ACC;
                    `ODSW_B_SUB:    op = OP_SUB;
                    `ODSW_B_DEC:    op = OP_DEC;
                    `ODSW_B_OR:     op = OP_OR;
                    `ODSW_B_AND:    op = OP_AND;
                    `ODSW_B_XOR:    op = OP_XOR;
                    `ODSW_B_ADD:    op = OP_ADD;
                    `ODSW_B_MOVE:   op = OP_MOVE;
                    `ODSW_B_COMP:   op = OP_COMP;
                    `ODSW_B_INC:    op = OP_INC;
                    `ODSW_B_DECSKZ: op = OP_DEC_SKZ;
                    `ODSW_B_RR:     op = OP_RR;
                    `ODSW_B_RL:     op = OP_RL;
                    `ODSW_B_SWAP:   op = OP_SWAP;
                    `ODSW_B_INCSKZ: op = OP_INC_SKZ;
                endcase
            end
            `ODSW_PFX_BIT: begin
                unique case (op4[3:2])
                    `ODSW_BIT_CLR:  op = OP_BIT_CLR;
                    `ODSW_BIT_SET:  op = OP_BIT_SET;
                    `ODSW_BIT_TSTC: op = OP_TEST_CLR;
                    `ODSW_BIT_TSTS: op = OP_TEST_SET;
                endcase
            end
            `ODSW_PFX_CTRL: op = op4[3] ? OP_JUMP : OP_CALL;
            `ODSW_PFX_LIT: begin
                if (op4[3:2] == `ODSW_L_LOAD)
                    op = OP_LIT_LOAD;
                else if (op4[3:2] == `ODSW_L_RET)
                    op = OP_LIT_RET;
                else if (op4 == `ODSW_L_OR)
                    op = OP_LIT_OR;
                else if (op4 == `ODSW_L_AND)
                    op = OP_LIT_AND;
                else if (op4 == `ODSW_L_XOR)
                    op = OP_LIT_XOR;
                else if (op4[3:1] == `ODSW_L_SUB)
                    op = OP_LIT_SUB;
                else if (op4[3:1] == `ODSW_L_ADD)
                    op = OP_LIT_ADD;
            end
        endcase
    end

    // Cycle count and status-flag classes
    wire logic arith = op inside {OP_ADD, OP_SUB, OP_LIT_ADD, OP_LIT_SUB};
    wire logic zonly = op inside {OP_OR, OP_AND, OP_XOR, OP_MOVE,
        OP_CLR_ACC, OP_CLR_FILE, OP_INC, OP_DEC, OP_COMP,
        OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR};

    assign dec_o.op        = op;
    assign dec_o.dest      = d;
    assign dec_o.faddr     = instr_i[6:0];
    assign dec_o.bitn      = instr_i[9:7];
    assign dec_o.lit       = instr_i[7:0];
    assign dec_o.target    = instr_i[10:0];
    assign dec_o.two_cycle = op inside {OP_CALL, OP_JUMP, OP_LIT_RET,
        OP_RET, OP_IRQ_RET};
    assign dec_o.may_skip  = op inside {OP_DEC_SKZ, OP_INC_SKZ,
        OP_TEST_CLR, OP_TEST_SET};
    assign dec_o.upd_c     = arith | (op inside {OP_RL, OP_RR});
    assign dec_o.upd_hc    = arith;
    assign dec_o.upd_z     = arith | zonly;
    assign dec_o.upd_tp    = op inside {OP_POWERDOWN, OP_WDT_CLEAR};

endmodule : odsw_decoder

// ### src/odsw_core.sv
// Instruction sequencer with power-down, watchdog and wake-up control
`timescale 1ns/1ps
`include "odsw_defs.svh"
module odsw_core
    import odsw_pkg::*;
#(
    parameter logic [`ODSW_WDT_W-1:0] WDT_CYCLES = `ODSW_WDT_CYCLES_DEF
)(
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   ext_reset_pin_n_i,
    input  wire logic [`ODSW_IW-1:0]    instr_i,
    input  wire logic [`ODSW_PCW-1:0]   ret_addr_i,
    input  wire logic                   skip_cond_i,
    input  wire logic                   wdt_enable_i,
    input  wire logic                   global_irq_enable_i,
    input  wire logic [`ODSW_IRQ_N-1:0] irq_flags_i,
    input  wire logic [`ODSW_IRQ_N-1:0] irq_enables_i,
    input  wire odsw_io_t               io_i,
    output logic [`ODSW_PCW-1:0]        fetch_addr_o,
    output odsw_dec_t                   dec_o,
    output odsw_exec_t                  exec_o,
    output logic                        vector_o,
    output logic [`ODSW_PCW-1:0]        vec_ret_o,
    output logic                        core_clk_en_o,
    output logic                        osc_drive_en_o,
    output logic                        core_reset_o,
    output logic                        wdt_reset_o,
    output logic                        powerdown_flag_o,
    output logic                        timeout_flag_o,
    output logic [`ODSW_WDT_W-1:0]      watchdog_counter_o,
    output odsw_io_t                    io_o
);
    odsw_state_t                state;
    odsw_state_t                next_state;
    odsw_dec_t                  dec;
    logic [1:0]                 rst_pin_sync;
    logic                       flush;
    logic                       vec_pend;
    logic [`ODSW_PCW-1:0]       pc;
    logic [`ODSW_PCW-1:0]       next_pc;
    logic [`ODSW_PCW-1:0]       exec_pc;
    logic [`ODSW_WDT_W-1:0]     wdt;
    logic [`ODSW_WDT_W-1:0]     next_wdt;

    odsw_decoder u_dec (
        .instr_i (instr_i),
        .dec_o   (dec)
    );

    // Reset pin is asynchronous to the core; two stages before use
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            rst_pin_sync <= 2'h0;
        else
            rst_pin_sync <= {rst_pin_sync[0], ext_reset_pin_n_i};
    end

    // Slot qualification and event decode
    wire logic ext_rst  = ~rst_pin_sync[1];
    wire logic run      = (state == ST_RUN) && !ext_rst;
    wire logic sleeping = (state == ST_SLEEP) && !ext_rst;
    wire logic skip_hit = exec_o.valid && !exec_o.nop_slot
                          && dec_o.may_skip && skip_cond_i;
    wire logic null_slot = flush | skip_hit;
    wire logic [`ODSW_WDT_W-1:0] wdt_inc =
        wdt + {{(`ODSW_WDT_W-1){1'b0}}, 1'b1};
    wire logic wdt_hit  = wdt_enable_i && (wdt_inc == WDT_CYCLES);
    // A wrap while running restarts the core, so the word is dropped
    wire logic take     = run && !null_slot && !wdt_hit;
    wire logic is_sleep = take && (dec.op == OP_POWERDOWN);
    wire logic pend_any = |(irq_flags_i & irq_enables_i);
    // Flags raised in the take cycle count as already pending
    wire logic sleep_go  = is_sleep && !pend_any;
    wire logic sleep_nop = is_sleep && pend_any;
    wire logic wdt_clr_ins = take && (dec.op == OP_WDT_CLEAR);
    // Only sources that run without core clocks may wake
    wire logic wake_irq = |(irq_flags_i & irq_enables_i
                          & `ODSW_WAKE_MASK);
    wire logic wake     = sleeping && (wake_irq || wdt_hit);
    wire logic wdt_rst  = run && wdt_hit;

    // Next program address of the instruction being taken
    always_comb begin
        unique case (dec.op)
            OP_CALL, OP_JUMP:
                exec_pc = {pc[`ODSW_PCW-1:`ODSW_TGTW], dec.target};
            OP_RET, OP_IRQ_RET, OP_LIT_RET:
                exec_pc = ret_addr_i;
            default:
                exec_pc = pc + `ODSW_PCW'(1);
        endcase
    end

    // Program counter selection, by priority
    always_comb begin
        if (ext_rst || wdt_rst)
            next_pc = `ODSW_PC_RESET;
        else if (!run || flush)
            next_pc = pc; // Refetch after a flushed slot
        else if (skip_hit)
            next_pc = pc + `ODSW_PCW'(1);
        else if (vec_pend)
            next_pc = `ODSW_PC_VECTOR;
        else
            next_pc = exec_pc;
    end

    // Run / sleep sequencing
    always_comb begin
        next_state = state;
        if (ext_rst)
            next_state = ST_RUN;
        else if (sleep_go)
            next_state = ST_SLEEP;
        else if (wake)
            next_state = ST_RUN;
    end

    // Watchdog keeps counting through sleep; cleared by the two ops
    always_comb begin
        if (sleep_go || wdt_clr_ins || wdt_hit || !wdt_enable_i)
            next_wdt = '0;
        else
            next_wdt = wdt_inc;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_RUN;
            pc    <= `ODSW_PC_RESET;
            wdt   <= '0;
        end else begin
            state <= next_state;
            pc    <= next_pc;
            wdt   <= next_wdt;
        end
    end

    // Two-cycle ops and vectoring flush the following fetch
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            flush <= 1'b0;
        else if (ext_rst || wdt_rst)
            flush <= 1'b0;
        else if (run)
            flush <= take && (dec.two_cycle || vec_pend);
    end

    // Vector request armed by an interrupt wake with global enable
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            vec_pend <= 1'b0;
        else if (ext_rst || wdt_rst)
            vec_pend <= 1'b0;
        else if (wake && wake_irq && global_irq_enable_i)
            vec_pend <= 1'b1;
        else if (take)
            vec_pend <= 1'b0;
    end

    // Vector pulse and the address to come back to
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vector_o  <= 1'b0;
            vec_ret_o <= `ODSW_PC_RESET;
        end else begin
            vector_o <= take && vec_pend && !wdt_rst;
            if (take && vec_pend)
                vec_ret_o <= exec_pc;
        end
    end

    // Executed slot; nulled and pending power-down slots run empty
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dec_o  <= '0;
            exec_o <= '0;
        end else begin
            exec_o.valid    <= run && !wdt_rst;
            exec_o.nop_slot <= null_slot || sleep_nop;
            if (take)
                dec_o <= dec;
        end
    end

    // Status flags; at most one event per cycle by construction
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            powerdown_flag_o <= 1'b1;
            timeout_flag_o   <= 1'b1;
        end else if (sleep_go) begin
            powerdown_flag_o <= 1'b0;
            timeout_flag_o   <= 1'b1;
        end else if (wdt_clr_ins) begin
            powerdown_flag_o <= 1'b1;
            timeout_flag_o   <= 1'b1;
        end else if (sleeping && wdt_hit) begin
            timeout_flag_o   <= 1'b0;
        end else if (wdt_rst) begin
            powerdown_flag_o <= 1'b1;
            timeout_flag_o   <= 1'b0;
        end
    end

    // Pins frozen while asleep so the board sees no glitch
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            io_o <= '0;
        else if (state == ST_RUN)
            io_o <= io_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            wdt_reset_o <= 1'b0;
        else
            wdt_reset_o <= wdt_rst;
    end

    // Clock gating and visible state
    assign core_clk_en_o      = run;
    assign osc_drive_en_o     = (state != ST_SLEEP);
    assign core_reset_o       = ext_rst;
    assign fetch_addr_o       = pc;
    assign watchdog_counter_o = wdt;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_sleep_go;
        run && !flush && !skip_hit && !wdt_hit && dec.op == OP_POWERDOWN
        && !(|(irq_flags_i & irq_enables_i));
    endsequence

    sequence s_gie_wake;
        state == ST_SLEEP && !ext_rst && global_irq_enable_i
        && |(irq_flags_i & irq_enables_i & `ODSW_WAKE_MASK);
    endsequence

    chk_sleep_entry: assert property (
        s_sleep_go |=> state == ST_SLEEP && !powerdown_flag_o
            && timeout_flag_o && watchdog_counter_o == '0)
        else $error("power-down entry state wrong");

    chk_sleep_prefetch: assert property (
        s_sleep_go |=> fetch_addr_o == $past(fetch_addr_o) + 13'h0001)
        else $error("power-down did not prefetch next address");

    chk_sleep_nop: assert property (
        take && dec.op == OP_POWERDOWN && pend_any
        |=> state == ST_RUN && $stable(powerdown_flag_o)
            && $stable(timeout_flag_o) && exec_o.nop_slot)
        else $error("pending interrupt power-down not a no-op");

    chk_osc_gated: assert property (
        state == ST_SLEEP |-> !osc_drive_en_o && !core_clk_en_o)
        else $error("clock active while powered down");

    chk_pins_hold: assert property (
        state == ST_SLEEP ##1 state == ST_SLEEP |-> $stable(io_o))
        else $error("pins moved while powered down");

    chk_wdt_wake: assert property (
        state == ST_SLEEP && !ext_rst && wdt_hit
        |=> state == ST_RUN && !timeout_flag_o)
        else $error("watchdog wake wrong");

    chk_mask_sleep: assert property (
        state == ST_SLEEP && !ext_rst && !wdt_hit
        && !(|(irq_flags_i & irq_enables_i & `ODSW_WAKE_MASK))
        |=> state == ST_SLEEP)
        else $error("woke without a qualifying source");

    chk_irq_vector: assert property (
        s_gie_wake ##1 core_clk_en_o && !flush && !skip_hit
        && !wdt_hit |=> vector_o && fetch_addr_o == `ODSW_PC_VECTOR)
        else $error("no vector after interrupt wake");

    chk_two_cycle: assert property (
        take && dec.two_cycle && !wdt_rst
        |=> ##1 exec_o.valid && exec_o.nop_slot || !exec_o.valid)
        else $error("two-cycle op lacks empty second slot");

    chk_skip_slot: assert property (
        run && skip_hit |=> exec_o.nop_slot)
        else $error("taken skip did not run an empty slot");

endmodule : odsw_core

// ### dv/odsw_prog_mem.sv
// Program memory model feeding instruction words to the core
`timescale 1ns/1ps
`include "odsw_defs.svh"
module odsw_prog_mem (
    input  wire logic [`ODSW_PCW-1:0] addr_i,
    output logic      [`ODSW_IW-1:0]  word_o
);
    logic [`ODSW_IW-1:0] mem [0:63];

    // Combinational read; beyond the loaded space the word keeps changing
    assign word_o = (addr_i < 13'h0040) ? mem[addr_i[5:0]] : {1'b0, ~addr_i};
endmodule : odsw_prog_mem

// ### dv/tb_opcode_decode_sleep_wake.sv
// Self-checking bench for the decoder and power-down sequencer
`timescale 1ns/1ps
`include "odsw_defs.svh"
module tb_opcode_decode_sleep_wake import odsw_pkg::*;;
    typedef struct packed {odsw_op_t op; logic nop;} odsw_note_t;
    logic                 clk_i = 0, resetn_i = 0, pin_n = 1, skip = 1;
    logic                 wdt_en = 0, global_irq_enable = 0, vec, clk_en, osc, pd, to;
    logic                 crst, wrst;
    logic [`ODSW_PCW-1:0] ret_addr = '0, fetch, vret;
    logic [`ODSW_IW-1:0]  instr;
    logic [15:0]          flags = '0, enables = '0;
    logic [23:0]          wdt;
    logic [31:0]          r;
    odsw_io_t             io_in = '0, io_out, hold;
    odsw_dec_t            dec;
    odsw_exec_t           ex;
    odsw_note_t           n;
    odsw_note_t           q[$];
    int                   num_errors = 0, checks_done = 0, seed = 57, ptr;

    odsw_prog_mem mem (.addr_i(fetch), .word_o(instr));
    odsw_core #(.WDT_CYCLES(24'h000020)) uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ext_reset_pin_n_i(pin_n),
        .instr_i(instr), .ret_addr_i(ret_addr), .skip_cond_i(skip),
        .wdt_enable_i(wdt_en), .global_irq_enable_i(global_irq_enable),
        .irq_flags_i(flags), .irq_enables_i(enables), .io_i(io_in),
        .fetch_addr_o(fetch), .dec_o(dec), .exec_o(ex), .vector_o(vec),
        .vec_ret_o(vret), .core_clk_en_o(clk_en), .osc_drive_en_o(osc),
        .core_reset_o(crst), .wdt_reset_o(wrst), .powerdown_flag_o(pd),
        .timeout_flag_o(to), .watchdog_counter_o(wdt), .io_o(io_out));

    initial forever #4 clk_i = ~clk_i;

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Flag-update set {carry, half carry, zero, timeout/power-down}
    function automatic logic [3:0] upd(input odsw_op_t op);
        case (op)
            OP_ADD, OP_SUB, OP_LIT_ADD, OP_LIT_SUB: upd = 4'hE;
            OP_RR, OP_RL: upd = 4'h8;
            OP_POWERDOWN, OP_WDT_CLEAR: upd = 4'h1;
            OP_CLR_ACC, OP_CLR_FILE, OP_DEC, OP_OR, OP_AND, OP_XOR, OP_MOVE,
            OP_COMP, OP_INC, OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR: upd = 4'h2;
            default: upd = 4'h0;
        endcase
    endfunction : upd

    // Load a word and note the slots it should retire
    task automatic put(input logic [13:0] w, input odsw_op_t op,
                       input logic nop = 1'b0);
        mem.mem[ptr] = w;
        q.push_back('{op, nop});
        ptr++;
        if (op inside {OP_DEC_SKZ, OP_INC_SKZ, OP_TEST_CLR, OP_TEST_SET})
            put(14'h0000, OP_NOP, 1'b1);
        else if (op inside {OP_CALL, OP_JUMP, OP_LIT_RET})
            q.push_back('{OP_NOP, 1'b1});
    endtask : put

    task automatic restart();
        resetn_i = 0;
        q.delete();
        ptr = 0;
        for (int i = 0; i < 64; i++) mem.mem[i] = 14'h0000;
        repeat (5) @(negedge clk_i);
    endtask : restart

    // Each executed slot retires the oldest note
    always @(negedge clk_i) begin
        if (ex.valid === 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            check(ex.nop_slot, n.nop);
            if (!n.nop) check({dec.op, dec.upd_c, dec.upd_hc, dec.upd_z,
                dec.upd_tp}, {n.op, upd(n.op)});
        end
    end

    initial begin
        // Decode sweep with random fields, skips held true
        restart();
        for (int c = 2; c < 16; c++) begin
            r = $random(seed);
            put({2'h0, 4'(c), r[7:0]}, odsw_op_t'(c + 2));
        end
        put({7'h03, r[6:0]}, OP_CLR_FILE);
        put({7'h02, r[6:0]}, OP_CLR_ACC);
        put({7'h01, r[6:0]}, OP_STORE_ACC);
        put({7'h00, r[1:0], 5'h00}, OP_NOP);
        for (int b = 0; b < 4; b++) put({2'h1, 2'(b), r[9:0]},
            odsw_op_t'(b + 18));
        put({3'h4, 11'(ptr + 1)}, OP_CALL);
        put({3'h5, 11'(ptr + 1)}, OP_JUMP);
        put({4'hC, r[9:0]}, OP_LIT_LOAD);
        put({6'h38, r[7:0]}, OP_LIT_OR);
        put({6'h39, r[7:0]}, OP_LIT_AND);
        put({6'h3A, r[7:0]}, OP_LIT_XOR);
        put({5'h1E, r[8:0]}, OP_LIT_SUB);
        put({5'h1F, r[8:0]}, OP_LIT_ADD);
        ret_addr = 13'(ptr + 1);
        put({4'hD, r[9:0]}, OP_LIT_RET);
        put(14'h0064, OP_WDT_CLEAR);
        put(14'h0063, OP_POWERDOWN);
        put({4'hC, 10'h2A5}, OP_LIT_LOAD);
        q.push_back('{OP_NOP, 1'b1});
        resetn_i = 1;
        for (int i = 0; i < 200 && osc !== 1'b0; i++) @(negedge clk_i);
        check({pd, to, osc, clk_en}, 4'h4);
        check(fetch, ptr - 1);
        // Clock-bound or unenabled sources must not wake
        hold = io_out;
        r = $random(seed);
        io_in = r[15:0];
        flags = 16'hF804;
        enables = 16'hF800;
        repeat (8) @(negedge clk_i);
        check(clk_en, 1'b0);
        check(io_out, hold);
        global_irq_enable = 1;
        enables[2] = 1'b1;
        for (int i = 0; i < 20 && vec !== 1'b1; i++) @(negedge clk_i);
        check({vec, fetch, vret}, {1'b1, 13'h0004, 13'(ptr)});
        // The flushed slot after the vector retires one cycle later
        repeat (2) @(negedge clk_i);
        check(q.size(), 0);
        // Pending enabled flag turns power-down into a no-op
        restart();
        global_irq_enable = 0;
        flags = 16'h0001;
        enables = 16'h0001;
        wdt_en = 1;
        put(14'h0063, OP_POWERDOWN, 1'b1);
        put({4'hC, 10'h000}, OP_LIT_LOAD);
        put(14'h0063, OP_POWERDOWN);
        resetn_i = 1;
        for (int i = 0; i < 20 && fetch !== 13'h0002; i++) @(negedge clk_i);
        check({pd, to, clk_en}, 3'h7);
        check(wdt, 24'h000004);
        flags = 16'h0000;
        for (int i = 0; i < 20 && clk_en !== 1'b0; i++) @(negedge clk_i);
        check(wdt, 24'h000000);
        for (int i = 0; i < 100 && clk_en !== 1'b1; i++) @(negedge clk_i);
        check({pd, to}, 2'h0);
        wdt_en = 0;
        pin_n = 0;
        repeat (3) @(negedge clk_i);
        check({crst, clk_en, fetch, pd}, 16'h8000);
        // Watchdog wrap while running; pending flag keeps words awake
        flags = 16'h0001;
        pin_n = 1;
        wdt_en = 1;
        for (int i = 0; i < 60 && wrst !== 1'b1; i++) @(negedge clk_i);
        check({wrst, fetch, pd, to}, {1'b1, 13'h0000, 2'h2});
        stop_test();
    end

    initial begin
        #50000;
        num_errors++;
        stop_test();
    end
endmodule : tb_opcode_decode_sleep_wake
